// *** logic/exec_unit_pkg.sv ***
// constants, command codes and register map of the add, logic, shift and branch unit
// assumes an apb master on pclk; operands are placed in the operand register first
// ****************************************************************************
// How it works
// - index add sums unsigned second accumulator, flags kept
// - add with carry sums byte plus carry
// - plain add sums byte without carry
// - double add uses two bytes, half-carry kept
// - 8-bit adds set half-carry from low nibble
// - accumulator adds set negative from sign, zero on zero
// - accumulator adds set overflow and carry from result
// - and stores result, clears overflow, keeps h,c
// - flag mask ands flag register with immediate
// - left shift moves bits up, zero in
// - shift carry gets old top bit, nz
// - shift overflow is old bit six xor seven
// - carry clear branch taken when carry zero
// - carry set branch taken when carry one
// - equal branch taken when zero flag set
// - signed ge branch when negative equals overflow
// - signed gt also needs zero flag clear
// - branches never change the flag register
// - unsigned higher branch needs carry, zero clear
// ****************************************************************************
package exec_unit_pkg;

  // ****************************************************************************
  // register map, byte addresses
  // ****************************************************************************
  localparam logic [11:0] OFS_FIRST_ACCUMULATOR     = 12'h000;
  localparam logic [11:0] OFS_SECOND_ACCUMULATOR    = 12'h004;
  localparam logic [11:0] OFS_FIRST_INDEX_REGISTER  = 12'h008;
  localparam logic [11:0] OFS_FLAG_REGISTER         = 12'h00C;
  localparam logic [11:0] OFS_PROGRAM_COUNTER       = 12'h010;
  localparam logic [11:0] OFS_MEMORY_OPERAND        = 12'h014;
  localparam logic [11:0] OFS_COMMAND               = 12'h018;
  localparam logic [11:0] OFS_WRITEBACK_DATA        = 12'h01C;
  localparam logic [11:0] OFS_STATUS                = 12'h020;

  // ****************************************************************************
  // field positions
  // ****************************************************************************
  localparam int FLAG_C         = 0;
  localparam int FLAG_V         = 1;
  localparam int FLAG_Z         = 2;
  localparam int FLAG_N         = 3;
  localparam int FLAG_H         = 5;
  localparam int CMD_SEL_BIT    = 4;
  localparam int CMD_MEM_BIT    = 5;
  localparam int CMD_LONG_BIT   = 6;
  localparam int STAT_TAKEN     = 0;
  localparam int STAT_WB_VALID  = 1;

  // ****************************************************************************
  // reset values
  // ****************************************************************************
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [6:0]  RST_CMD   = 7'h00;

  // ****************************************************************************
  // command codes, low nibble of the command register
  // ****************************************************************************
  localparam logic [3:0] OP_NOP                      = 4'h0;
  localparam logic [3:0] OP_ADD_B_INTO_FIRST_INDEX   = 4'h1;
  localparam logic [3:0] OP_ADD_WITH_CARRY           = 4'h2;
  localparam logic [3:0] OP_ADD_PLAIN                = 4'h3;
  localparam logic [3:0] OP_DOUBLE_ACCUMULATOR_SUM   = 4'h4;
  localparam logic [3:0] OP_ACC_BITWISE_AND          = 4'h5;
  localparam logic [3:0] OP_FLAG_REGISTER_MASK       = 4'h6;
  localparam logic [3:0] OP_ARITH_SHIFT_LEFT         = 4'h7;
  localparam logic [3:0] OP_BRANCH_CARRY_CLEAR       = 4'h8;
  localparam logic [3:0] OP_BRANCH_CARRY_SET         = 4'h9;
  localparam logic [3:0] OP_BRANCH_IF_EQUAL          = 4'hA;
  localparam logic [3:0] OP_BRANCH_SIGNED_GE         = 4'hB;
  localparam logic [3:0] OP_BRANCH_SIGNED_GT         = 4'hC;
  localparam logic [3:0] OP_BRANCH_UNSIGNED_HIGHER   = 4'hD;

endpackage

// *** logic/exec_unit.sv ***
// add, logic, shift and conditional branch unit with an apb register file
// assumes an apb master on pclk; a write to the command register executes at once
module exec_unit
  import exec_unit_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  // ****************************************************************************
  // state
  // ****************************************************************************
  typedef struct packed {
    logic [7:0]  first_accumulator;
    logic [7:0]  second_accumulator;
    logic [15:0] first_index_register;
    logic [7:0]  flag_register;
    logic [15:0] program_counter;
    logic [15:0] memory_operand;
    logic [6:0]  command;
    logic [7:0]  writeback_data;
    logic        writeback_valid;
    logic        taken;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t q;
  state_t d;

  // ****************************************************************************
  // helpers
  // ****************************************************************************
  // returns {half, overflow, carry, sum}
  function automatic logic [10:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       cin);
    logic [8:0] s;
    logic [4:0] lo;
    logic       v;
    s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    v  = (a[7] == b[7]) && (s[7] != a[7]);
    return {lo[4], v, s[8], s[7:0]};
  endfunction

  function automatic logic [7:0] with_nz(input logic [7:0] f,
                                         input logic       neg,
                                         input logic       zero);
    logic [7:0] r;
    r         = f;
    r[FLAG_N] = neg;
    r[FLAG_Z] = zero;
    return r;
  endfunction

  function automatic logic is_branch(input logic [3:0] op);
    return (op >= OP_BRANCH_CARRY_CLEAR) && (op <= OP_BRANCH_UNSIGNED_HIGHER);
  endfunction

  function automatic logic branch_cond(input logic [3:0] op, input logic [7:0] f);
    logic r;
    r = 1'b0;
    case (op)
      OP_BRANCH_CARRY_CLEAR:     r = ~f[FLAG_C];
      OP_BRANCH_CARRY_SET:       r = f[FLAG_C];
      OP_BRANCH_IF_EQUAL:        r = f[FLAG_Z];
      OP_BRANCH_SIGNED_GE:       r = ~(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_SIGNED_GT:       r = ~(f[FLAG_Z] | (f[FLAG_N] ^ f[FLAG_V]));
      OP_BRANCH_UNSIGNED_HIGHER: r = ~(f[FLAG_C] | f[FLAG_Z]);
      default:                   r = 1'b0;
    endcase
    return r;
  endfunction

  // short form takes the low byte sign-extended, long form the whole word
  function automatic logic [15:0] branch_offset(input logic [15:0] opnd,
                                                input logic        long_form);
    return long_form ? opnd : {{8{opnd[7]}}, opnd[7:0]};
  endfunction

  // ****************************************************************************
  // bus decode
  // ****************************************************************************
  logic       setup;
  logic       take;
  logic       cmd_go;
  logic [3:0] go_op;
  logic       go_sel;
  logic       go_mem;
  logic       go_long;

  assign setup   = psel & ~penable;
  assign take    = psel & penable & q.pready;
  assign cmd_go  = take & pwrite & (paddr == OFS_COMMAND);
  assign go_op   = pwdata[3:0];
  assign go_sel  = pwdata[CMD_SEL_BIT];
  assign go_mem  = pwdata[CMD_MEM_BIT];
  assign go_long = pwdata[CMD_LONG_BIT];

  // ****************************************************************************
  // next state
  // ****************************************************************************
  always_comb begin
    logic [7:0]  acc;
    logic [7:0]  res8;
    logic        wr_acc;
    logic [10:0] s8;
    logic [16:0] s16;
    logic [7:0]  src;
    logic [31:0] rd;
    logic        hit;
    acc    = go_sel ? q.second_accumulator : q.first_accumulator;
    res8   = RST_BYTE;
    wr_acc = 1'b0;
    s8     = 11'h000;
    s16    = 17'h00000;
    src    = RST_BYTE;
    rd     = 32'h0000_0000;
    hit    = 1'b1;
    d      = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // read data is captured in the setup cycle and answered in the access cycle
    if (paddr == OFS_FIRST_ACCUMULATOR) begin
      rd[7:0] = q.first_accumulator;
    end else if (paddr == OFS_SECOND_ACCUMULATOR) begin
      rd[7:0] = q.second_accumulator;
    end else if (paddr == OFS_FIRST_INDEX_REGISTER) begin
      rd[15:0] = q.first_index_register;
    end else if (paddr == OFS_FLAG_REGISTER) begin
      rd[7:0] = q.flag_register;
    end else if (paddr == OFS_PROGRAM_COUNTER) begin
      rd[15:0] = q.program_counter;
    end else if (paddr == OFS_MEMORY_OPERAND) begin
      rd[15:0] = q.memory_operand;
    end else if (paddr == OFS_COMMAND) begin
      rd[6:0] = q.command;
    end else if (paddr == OFS_WRITEBACK_DATA) begin
      rd[7:0] = q.writeback_data;
    end else if (paddr == OFS_STATUS) begin
      rd[STAT_TAKEN]    = q.taken;
      rd[STAT_WB_VALID] = q.writeback_valid;
    end else begin
      hit = 1'b0;
    end

    if (setup) begin
      d.pready  = 1'b1;
      d.pslverr = ~hit;
      d.prdata  = pwrite ? 32'h0000_0000 : rd;
    end

    // reading the write-back byte clears the write-back valid flag
    if (take && !pwrite && (paddr == OFS_WRITEBACK_DATA)) begin
      d.writeback_valid = 1'b0;
    end

    if (take && pwrite) begin
      if (paddr == OFS_FIRST_ACCUMULATOR) begin
        d.first_accumulator = pwdata[7:0];
      end else if (paddr == OFS_SECOND_ACCUMULATOR) begin
        d.second_accumulator = pwdata[7:0];
      end else if (paddr == OFS_FIRST_INDEX_REGISTER) begin
        d.first_index_register = pwdata[15:0];
      end else if (paddr == OFS_FLAG_REGISTER) begin
        d.flag_register = pwdata[7:0];
      end else if (paddr == OFS_PROGRAM_COUNTER) begin
        d.program_counter = pwdata[15:0];
      end else if (paddr == OFS_MEMORY_OPERAND) begin
        d.memory_operand = pwdata[15:0];
      end else if (paddr == OFS_COMMAND) begin
        d.command = pwdata[6:0];
      end
    end

    // ****************************************************************************
    // execution
    // ****************************************************************************
    if (cmd_go) begin
      case (go_op)
        OP_ADD_B_INTO_FIRST_INDEX: begin
          d.first_index_register = q.first_index_register + {8'h00, q.second_accumulator};
        end
        OP_ADD_WITH_CARRY, OP_ADD_PLAIN: begin
          s8 = add8(acc, q.memory_operand[7:0],
                    (go_op == OP_ADD_WITH_CARRY) & q.flag_register[FLAG_C]);
          res8   = s8[7:0];
          wr_acc = 1'b1;
          d.flag_register          = with_nz(q.flag_register, res8[7], res8 == 8'h00);
          d.flag_register[FLAG_H]  = s8[10];
          d.flag_register[FLAG_V]  = s8[9];
          d.flag_register[FLAG_C]  = s8[8];
        end
        OP_DOUBLE_ACCUMULATOR_SUM: begin
          s16 = {1'b0, q.first_accumulator, q.second_accumulator}
              + {1'b0, q.memory_operand};
          d.first_accumulator  = s16[15:8];
          d.second_accumulator = s16[7:0];
          d.flag_register = with_nz(q.flag_register, s16[15], s16[15:0] == 16'h0000);
          d.flag_register[FLAG_V] = (q.first_accumulator[7] == q.memory_operand[15])
                                  && (s16[15] != q.first_accumulator[7]);
          d.flag_register[FLAG_C] = s16[16];
        end
        OP_ACC_BITWISE_AND: begin
          res8   = acc & q.memory_operand[7:0];
          wr_acc = 1'b1;
          d.flag_register         = with_nz(q.flag_register, res8[7], res8 == 8'h00);
          d.flag_register[FLAG_V] = 1'b0;
        end
        OP_FLAG_REGISTER_MASK: begin
          d.flag_register = q.flag_register & q.memory_operand[7:0];
        end
        OP_ARITH_SHIFT_LEFT: begin
          src  = go_mem ? q.memory_operand[7:0] : acc;
          res8 = {src[6:0], 1'b0};
          d.flag_register         = with_nz(q.flag_register, res8[7], res8 == 8'h00);
          d.flag_register[FLAG_C] = src[7];
          d.flag_register[FLAG_V] = src[7] ^ src[6];
          if (go_mem) begin
            d.writeback_data  = res8;
            d.writeback_valid = 1'b1;
          end else begin
            wr_acc = 1'b1;
          end
        end
        default: begin
          // branches leave the flag register alone
          if (is_branch(go_op)) begin
            d.taken = branch_cond(go_op, q.flag_register);
            if (branch_cond(go_op, q.flag_register)) begin
              d.program_counter = q.program_counter
                                + branch_offset(q.memory_operand, go_long);
            end
          end
        end
      endcase
      if (wr_acc) begin
        if (go_sel) begin
          d.second_accumulator = res8;
        end else begin
          d.first_accumulator = res8;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{first_accumulator:    RST_BYTE,
             second_accumulator:   RST_BYTE,
             first_index_register: RST_WORD,
             flag_register:        RST_FLAGS,
             program_counter:      RST_WORD,
             memory_operand:       RST_WORD,
             command:              RST_CMD,
             writeback_data:       RST_BYTE,
             writeback_valid:      1'b0,
             taken:                1'b0,
             pready:               1'b0,
             pslverr:              1'b0,
             prdata:               32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  assign pready  = q.pready;
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr;

  // ****************************************************************************
  // checks
  // ****************************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_index_add;
    cmd_go && go_op == OP_ADD_B_INTO_FIRST_INDEX |=>
      q.first_index_register == 16'($past(q.first_index_register)
                                    + {8'h00, $past(q.second_accumulator)})
      && q.flag_register == $past(q.flag_register);
  endproperty
  a_index_add: assert property (p_index_add) else $error("index add wrong");

  property p_carry_add;
    cmd_go && go_op == OP_ADD_WITH_CARRY && go_sel |=>
      q.second_accumulator == 8'($past(q.second_accumulator) + $past(q.memory_operand[7:0])
                                 + {7'h00, $past(q.flag_register[FLAG_C])});
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("add with carry wrong");

  property p_plain_add;
    cmd_go && go_op == OP_ADD_PLAIN && !go_sel |=>
      q.first_accumulator == 8'($past(q.first_accumulator) + $past(q.memory_operand[7:0]))
      && q.second_accumulator == $past(q.second_accumulator);
  endproperty
  a_plain_add: assert property (p_plain_add) else $error("plain add wrong");

  property p_half_carry;
    cmd_go && go_op == OP_ADD_PLAIN && !go_sel |=>
      q.flag_register[FLAG_H] == (({1'b0, $past(q.first_accumulator[3:0])}
                                   + {1'b0, $past(q.memory_operand[3:0])}) > 5'h0F);
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half carry wrong");

  property p_add_flags;
    cmd_go && go_op == OP_ADD_PLAIN && !go_sel |=>
      q.flag_register[FLAG_N] == q.first_accumulator[7]
      && q.flag_register[FLAG_Z] == (q.first_accumulator == 8'h00)
      && q.flag_register[FLAG_V] == (($past(q.first_accumulator[7])
                                      == $past(q.memory_operand[7]))
                                     && (q.first_accumulator[7]
                                         != $past(q.first_accumulator[7])));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_double_sum;
    cmd_go && go_op == OP_DOUBLE_ACCUMULATOR_SUM |=>
      {q.first_accumulator, q.second_accumulator}
        == 16'({$past(q.first_accumulator), $past(q.second_accumulator)}
               + $past(q.memory_operand))
      && q.flag_register[FLAG_H] == $past(q.flag_register[FLAG_H])
      && q.flag_register[FLAG_C] == (({1'b0, $past(q.first_accumulator),
                                       $past(q.second_accumulator)}
                                      + {1'b0, $past(q.memory_operand)}) > 17'h0FFFF);
  endproperty
  a_double_sum: assert property (p_double_sum) else $error("double add wrong");

  property p_and_flags;
    cmd_go && go_op == OP_ACC_BITWISE_AND && !go_sel |=>
      q.first_accumulator == ($past(q.first_accumulator) & $past(q.memory_operand[7:0]))
      && !q.flag_register[FLAG_V]
      && q.flag_register[FLAG_C] == $past(q.flag_register[FLAG_C])
      && q.flag_register[FLAG_H] == $past(q.flag_register[FLAG_H]);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and result or flags wrong");

  property p_mask;
    cmd_go && go_op == OP_FLAG_REGISTER_MASK |=>
      q.flag_register == ($past(q.flag_register) & $past(q.memory_operand[7:0]));
  endproperty
  a_mask: assert property (p_mask) else $error("flag mask wrong");

  property p_shift_acc;
    cmd_go && go_op == OP_ARITH_SHIFT_LEFT && !go_mem && !go_sel |=>
      q.first_accumulator == {$past(q.first_accumulator[6:0]), 1'b0}
      && q.flag_register[FLAG_C] == $past(q.first_accumulator[7])
      && q.flag_register[FLAG_V] == ($past(q.first_accumulator[7])
                                     ^ $past(q.first_accumulator[6]));
  endproperty
  a_shift_acc: assert property (p_shift_acc) else $error("shift wrong");

  property p_shift_mem;
    cmd_go && go_op == OP_ARITH_SHIFT_LEFT && go_mem |=>
      q.writeback_valid && q.writeback_data == {$past(q.memory_operand[6:0]), 1'b0}
      && q.first_accumulator == $past(q.first_accumulator);
  endproperty
  a_shift_mem: assert property (p_shift_mem) else $error("memory shift wrong");

  property p_branch;
    cmd_go && is_branch(go_op) |=>
      q.flag_register == $past(q.flag_register)
      && q.taken == branch_cond($past(go_op), $past(q.flag_register))
      && q.program_counter == (q.taken ? 16'($past(q.program_counter)
                                             + branch_offset($past(q.memory_operand),
                                                             $past(go_long)))
                                       : $past(q.program_counter));
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch wrong");

  property p_signed_gt;
    cmd_go && go_op == OP_BRANCH_SIGNED_GT |=>
      q.taken == (!$past(q.flag_register[FLAG_Z])
                  && ($past(q.flag_register[FLAG_N]) == $past(q.flag_register[FLAG_V])));
  endproperty
  a_signed_gt: assert property (p_signed_gt) else $error("signed gt wrong");

  property p_bus_answer;
    setup |=> pready ##1 !pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("apb answer timing wrong");

endmodule

// *** dv/mem_model.sv ***
// memory model that hands the bench operand bytes
// assumes the bench copies the bytes into the operand register
module mem_model (
  input  wire logic [7:0]  addr,
  output logic      [15:0] rd_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
  end
  // byte at the address, then byte at the next address
  assign rd_word = {mem[addr], mem[addr + 8'h01]};
endmodule

// *** dv/tb_exec_unit.sv ***
// self-checking bench of the execution unit over apb
// assumes apb answers within the watchdog span and the package register map
module tb_exec_unit
  import exec_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  maddr;
  logic [15:0] mword, r;
  logic [7:0]  av [4] = '{8'h0F, 8'h7F, 8'hFF, 8'h80};
  logic [7:0]  fv [4] = '{8'h00, 8'h05, 8'h08, 8'h0A};
  logic        tk;
  int          failures, total_checks;
  exec_unit i_exec_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  mem_model i_mem_model (.addr(maddr), .rd_word(mword));
  always #5 pclk = ~pclk;
  // ****
  // tasks
  // ****
  task summarize;
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x, input logic [11:0] a);
    total_checks++;
    if (s !== x) begin
      failures++;
      $display("wrong value reg %h expected %h seen %h", a, x, s);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [15:0] x);
    xfer(1'b0, a, 16'h0000);
    chk(q, {16'h0000, x}, a);
    chk({31'h0, e}, 32'h0, a);
  endtask
  // flags in high byte, sum in low byte
  function automatic logic [15:0] add_x(input logic [7:0] a, m, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    s = a + m + c;
    h = a[3:0] + m[3:0] + c;
    return {2'b00, h[4], 1'b0, s[7], s[7:0] == 8'h00,
            (a[7] == m[7]) && (s[7] != a[7]), s[8], s[7:0]};
  endfunction
  function automatic logic br_x(input logic [3:0] op, input logic [7:0] f);
    case (op)
      4'h8: return !f[0];
      4'h9: return f[0];
      4'hA: return f[2];
      4'hB: return f[3] == f[1];
      4'hC: return !f[2] && f[3] == f[1];
      default: return !f[0] && !f[2];
    endcase
  endfunction
  initial begin
    #100000;
    failures++;
    summarize;
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0; maddr = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rd(a[11:0], 16'h0000);
    xfer(1'b0, 12'h024, 16'h0000);
    chk({31'h0, e}, 32'h1, 12'h024);
    wr(12'h030, 16'h00FF);
    chk({31'h0, e}, 32'h1, 12'h030);
    wr(OFS_STATUS, 16'h0003);
    rd(OFS_STATUS, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = add_x(av[i], av[i] == 8'h80 ? 8'h80 : 8'h01, 1'b0);
      wr(OFS_FIRST_ACCUMULATOR, {8'h00, av[i]});
      wr(OFS_SECOND_ACCUMULATOR, {8'h00, av[i]});
      wr(OFS_FLAG_REGISTER, 16'h0001);
      wr(OFS_MEMORY_OPERAND, av[i] == 8'h80 ? 16'h0080 : 16'h0001);
      wr(OFS_COMMAND, {12'h000, OP_ADD_PLAIN});
      rd(OFS_FIRST_ACCUMULATOR, {8'h00, r[7:0]});
      rd(OFS_FLAG_REGISTER, {8'h00, r[15:8]});
      r = add_x(av[i], av[i] == 8'h80 ? 8'h80 : 8'h01, 1'b1);
      wr(OFS_FLAG_REGISTER, 16'h0001);
      wr(OFS_COMMAND, {12'h001, OP_ADD_WITH_CARRY});
      rd(OFS_SECOND_ACCUMULATOR, {8'h00, r[7:0]});
      rd(OFS_FLAG_REGISTER, {8'h00, r[15:8]});
    end
    wr(OFS_FIRST_INDEX_REGISTER, 16'h12F0);
    wr(OFS_SECOND_ACCUMULATOR, 16'h00FF);
    wr(OFS_FLAG_REGISTER, 16'h00FF);
    wr(OFS_COMMAND, {12'h000, OP_ADD_B_INTO_FIRST_INDEX});
    rd(OFS_FIRST_INDEX_REGISTER, 16'h13EF);
    rd(OFS_FLAG_REGISTER, 16'h00FF);
    wr(OFS_FIRST_ACCUMULATOR, 16'h007F);
    wr(OFS_FLAG_REGISTER, 16'h0020);
    wr(OFS_MEMORY_OPERAND, mword);
    wr(OFS_COMMAND, {12'h000, OP_DOUBLE_ACCUMULATOR_SUM});
    rd(OFS_FIRST_ACCUMULATOR, 16'h0080);
    rd(OFS_SECOND_ACCUMULATOR, 16'h0000);
    rd(OFS_FLAG_REGISTER, 16'h002A);
    wr(OFS_FIRST_ACCUMULATOR, 16'h00F0);
    wr(OFS_MEMORY_OPERAND, 16'h000F);
    wr(OFS_FLAG_REGISTER, 16'h0023);
    wr(OFS_COMMAND, {12'h000, OP_ACC_BITWISE_AND});
    rd(OFS_FIRST_ACCUMULATOR, 16'h0000);
    rd(OFS_FLAG_REGISTER, 16'h0025);
    wr(OFS_SECOND_ACCUMULATOR, 16'h00C3);
    wr(OFS_COMMAND, {12'h001, OP_ACC_BITWISE_AND});
    rd(OFS_SECOND_ACCUMULATOR, 16'h0003);
    rd(OFS_FLAG_REGISTER, 16'h0021);
    wr(OFS_COMMAND, {12'h000, OP_NOP});
    rd(OFS_FLAG_REGISTER, 16'h0021);
    wr(OFS_FLAG_REGISTER, 16'h00FF);
    wr(OFS_MEMORY_OPERAND, 16'h005A);
    wr(OFS_COMMAND, {12'h000, OP_FLAG_REGISTER_MASK});
    rd(OFS_FLAG_REGISTER, 16'h005A);
    wr(OFS_FIRST_ACCUMULATOR, 16'h00C1);
    wr(OFS_FLAG_REGISTER, 16'h0000);
    wr(OFS_COMMAND, {12'h000, OP_ARITH_SHIFT_LEFT});
    rd(OFS_FIRST_ACCUMULATOR, 16'h0082);
    xfer(1'b0, OFS_FLAG_REGISTER, 16'h0000);
    chk(q & 32'hDF, 32'h09, OFS_FLAG_REGISTER);
    wr(OFS_MEMORY_OPERAND, 16'h0040);
    wr(OFS_COMMAND, {12'h002, OP_ARITH_SHIFT_LEFT});
    rd(OFS_STATUS, 16'h0002);
    rd(OFS_WRITEBACK_DATA, 16'h0080);
    rd(OFS_STATUS, 16'h0000);
    rd(OFS_FIRST_ACCUMULATOR, 16'h0082);
    xfer(1'b0, OFS_FLAG_REGISTER, 16'h0000);
    chk(q & 32'hDF, 32'h0A, OFS_FLAG_REGISTER);
    for (int op = 8; op <= 13; op++) begin
      for (int j = 0; j < 4; j++) begin
        tk = br_x(op[3:0], fv[j]);
        wr(OFS_PROGRAM_COUNTER, 16'h1000);
        wr(OFS_FLAG_REGISTER, {8'h00, fv[j]});
        wr(OFS_MEMORY_OPERAND, j[0] ? 16'h8000 : 16'h00FE);
        wr(OFS_COMMAND, {9'h000, j[0], 2'b00, op[3:0]});
        rd(OFS_PROGRAM_COUNTER, !tk ? 16'h1000 : j[0] ? 16'h9000 : 16'h0FFE);
        rd(OFS_STATUS, {15'h0000, tk});
        rd(OFS_FLAG_REGISTER, {8'h00, fv[j]});
      end
    end
    summarize;
  end
endmodule
